//--- pkg/cts_pkg.sv
// Constants and carrier types for the control table sequencer
package cts_pkg;

	// ----------------------------------------------------------------
	// Counter widths and fixed addresses
	// ----------------------------------------------------------------
	localparam int LINE_ADDR_W = 17;
	localparam int ROW_ADDR_W = 15;
	localparam int WINDOW_LEN_W = 17;
	localparam int TABLE_DATA_W = 8;
	localparam logic [LINE_ADDR_W-1:0] LINE_LOAD_ADDR = 17'h08000;
	localparam logic [LINE_ADDR_W-1:0] LINE_STICK_ADDR = 17'h07ff0;
	localparam logic [LINE_ADDR_W-1:0] LINE_ZERO_ADDR = 17'h00000;
	localparam logic [ROW_ADDR_W-1:0] ROW_LOAD_ADDR = 15'h2000;
	localparam logic [ROW_ADDR_W-1:0] ROW_STICK_ADDR = 15'h1ff0;
	localparam logic [ROW_ADDR_W-1:0] ROW_ZERO_ADDR = 15'h0000;

	// ----------------------------------------------------------------
	// Pixel clock divider
	// ----------------------------------------------------------------
	localparam int PIXELS_PER_GROUP = 8;
	localparam logic [2:0] GROUP_LAST = 3'h7;

	// ----------------------------------------------------------------
	// Line table bit positions
	// ----------------------------------------------------------------
	localparam int LT_WINDOW_BEGIN = 0;
	localparam int LT_CLEAR = 1;
	localparam int LT_FRAME_LOAD_MASK = 2;
	localparam int LT_HOST_IRQ = 3;
	localparam int LT_GENERAL_LSB = 4;

	// ----------------------------------------------------------------
	// Pixel table bit positions
	// ----------------------------------------------------------------
	localparam int PT_WINDOW_BEGIN = 0;
	localparam int PT_CLEAR = 1;
	localparam int PT_LINE_LOAD_MASK = 2;
	localparam int PT_GENERAL_LSB = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [TABLE_DATA_W-1:0] WORD_RESET = 8'h00;
	localparam logic [WINDOW_LEN_W-1:0] WINDOW_RESET = 17'h00000;

	// ----------------------------------------------------------------
	// Line counter clear source selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CTS_CLEAR_OFF = 2'b00,
		CTS_CLEAR_TABLE = 2'b01,
		CTS_CLEAR_TRIGGER = 2'b10,
		CTS_CLEAR_EITHER = 2'b11
	} cts_clear_src_t;

	// ----------------------------------------------------------------
	// Configuration and host table write carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		cts_clear_src_t lineClearSourceSel;
		logic lineZeroReleaseSel;
		logic lineStickReleaseSel;
		logic frameEdgePolarity;
		logic lineEdgePolarity;
		logic rowZeroReleaseSel;
		logic rowStickReleaseSel;
		logic frameStartFromTable;
		logic rowStartFromTable;
		logic [WINDOW_LEN_W-1:0] activeClocksPerRow;
	} cts_cfg_t;

	typedef struct packed {
		logic lineWrite;
		logic rowWrite;
		logic [LINE_ADDR_W-1:0] addr;
		logic [TABLE_DATA_W-1:0] data;
	} cts_table_wr_t;

endpackage

//--- rtl/cts_control_table_sequencer.sv
// Table-driven line and pixel-group waveform sequencers
module cts_control_table_sequencer
	import cts_pkg::*;
#(
	parameter int LINE_DEPTH = 131072,
	parameter int ROW_DEPTH = 32768
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pixelClockIn,
	input wire logic lineValidIn,
	input wire logic frameValidIn,
	input wire logic triggerIn,
	input wire logic encoderIn,
	input wire cts_cfg_t cfg,
	input wire cts_table_wr_t tableWr,
	output logic [LINE_ADDR_W-1:0] linePositionCount,
	output logic [ROW_ADDR_W-1:0] pixelGroupCount,
	output logic [TABLE_DATA_W-1:0] lineWord,
	output logic [TABLE_DATA_W-1:0] rowWord,
	output logic vertWindowBegin,
	output logic rowWindowBegin,
	output logic rowActiveWindow,
	output logic hostIrqRequest,
	output logic [3:0] generalVertFn,
	output logic [3:0] generalRowFn,
	output logic [3:0] cameraControl
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Fixed load addresses need the full documented table depths
	if (LINE_DEPTH != (1 << LINE_ADDR_W) || ROW_DEPTH != (1 << ROW_ADDR_W))
	begin : g_depth_check
		$error("Table depths must match the counter widths");
	end

	// Divider and word layout are fixed by the package constants
	if (PIXELS_PER_GROUP != 8 || GROUP_LAST != 3'h7 || TABLE_DATA_W != 8)
	begin : g_const_check
		$error("Package constants do not fit this logic");
	end

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	function automatic logic edgeSel(input logic now, input logic prev, input logic fallingSel);
		// Falling selection flips the sense of the compare
		edgeSel = fallingSel ? (prev & ~now) : (now & ~prev);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Pixel clock is sampled, so it must stay below half of ref_clk
	logic [4:0] pinMeta_reg;
	logic [4:0] pinSync_reg;
	logic [4:0] pinPrev_reg;
	wire [4:0] pinRaw = {encoderIn, triggerIn, frameValidIn, lineValidIn, pixelClockIn};

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			pinMeta_reg <= 5'h00;
			pinSync_reg <= 5'h00;
			pinPrev_reg <= 5'h00;
		end
		else
		begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			pinPrev_reg <= pinSync_reg;
		end
	end

	// ----------------------------------------------------------------
	// Pin edges
	// ----------------------------------------------------------------
	// Edges come in the same cycle as the synchronised level
	wire pixelEdge = pinSync_reg[0] & ~pinPrev_reg[0];
	wire lineEdge = edgeSel(pinSync_reg[1], pinPrev_reg[1], cfg.lineEdgePolarity);
	wire frameEdge = edgeSel(pinSync_reg[2], pinPrev_reg[2], cfg.frameEdgePolarity);
	wire triggerLevel = pinSync_reg[3];
	wire triggerRise = pinSync_reg[3] & ~pinPrev_reg[3];
	wire encoderLevel = pinSync_reg[4];
	wire lineStart = pinSync_reg[1] & ~pinPrev_reg[1];

	// ----------------------------------------------------------------
	// Pixel clock divide by eight
	// ----------------------------------------------------------------
	logic [2:0] groupPhase_reg;
	// Phase is cleared only by reset, so loads do not shift the tick grid
	wire groupTick = pixelEdge && (groupPhase_reg == GROUP_LAST);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			groupPhase_reg <= 3'h0;
		else if (pixelEdge)
			groupPhase_reg <= groupPhase_reg + 3'h1;
	end

	// ----------------------------------------------------------------
	// Table memories
	// ----------------------------------------------------------------
	logic [TABLE_DATA_W-1:0] lineTableMemory [0:LINE_DEPTH-1];
	logic [TABLE_DATA_W-1:0] pixelTableMemory [0:ROW_DEPTH-1];
	// Tables are not reset, so unwritten words read as unknown

	// ----------------------------------------------------------------
	// Host table writes
	// ----------------------------------------------------------------
	// Host writes go straight to storage; counters are never touched
	// Row writes use the low address bits only
	always_ff @(posedge ref_clk)
	begin
		if (tableWr.lineWrite)
			lineTableMemory[tableWr.addr] <= tableWr.data;
	end

	always_ff @(posedge ref_clk)
	begin
		if (tableWr.rowWrite)
			pixelTableMemory[tableWr.addr[ROW_ADDR_W-1:0]] <= tableWr.data;
	end

	logic [LINE_ADDR_W-1:0] lineCount_reg;
	logic [LINE_ADDR_W-1:0] lineCount_next;
	logic [ROW_ADDR_W-1:0] rowCount_reg;
	logic [ROW_ADDR_W-1:0] rowCount_next;
	logic [TABLE_DATA_W-1:0] lineWord_reg;
	logic [TABLE_DATA_W-1:0] rowWord_reg;

	// ----------------------------------------------------------------
	// Table word registers
	// ----------------------------------------------------------------
	// Word follows its address one cycle later; ticks are far apart
	// Holding the address holds the word, so an inhibited counter freezes it
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			lineWord_reg <= WORD_RESET;
		else
			lineWord_reg <= lineTableMemory[lineCount_reg];
	end

	// A read in the write cycle still sees the old word
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			rowWord_reg <= WORD_RESET;
		else
			rowWord_reg <= pixelTableMemory[rowCount_reg];
	end

	// ----------------------------------------------------------------
	// Pixel group counter
	// ----------------------------------------------------------------
	// Clear only at a tick, so each table entry acts once
	wire rowClear = groupTick && rowWord_reg[PT_CLEAR];
	wire rowAtStick = (rowCount_reg == ROW_STICK_ADDR);
	wire rowStuck = cfg.rowStickReleaseSel && rowAtStick;
	wire rowHoldZero = cfg.rowZeroReleaseSel && (rowCount_reg == ROW_ZERO_ADDR) && !encoderLevel;
	wire rowLoad = lineEdge && (rowWord_reg[PT_LINE_LOAD_MASK] || rowStuck);
	wire rowInc = groupTick && !rowHoldZero && !rowStuck;
	wire lineEnd = rowClear;

	always_comb
	begin
		rowCount_next = rowCount_reg;
		if (rowClear)
			rowCount_next = ROW_ZERO_ADDR;
		else if (rowLoad)
			rowCount_next = ROW_LOAD_ADDR;
		else if (rowInc)
			rowCount_next = rowCount_reg + 15'h0001;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			rowCount_reg <= ROW_ZERO_ADDR;
		else
			rowCount_reg <= rowCount_next;
	end

	// ----------------------------------------------------------------
	// Line position counter
	// ----------------------------------------------------------------
	wire lineAtStick = (lineCount_reg == LINE_STICK_ADDR);
	wire lineStuck = cfg.lineStickReleaseSel && lineAtStick;
	wire lineHoldZero = cfg.lineZeroReleaseSel && (lineCount_reg == LINE_ZERO_ADDR) && !triggerLevel;
	wire lineLoad = frameEdge && (lineWord_reg[LT_FRAME_LOAD_MASK] || lineStuck);
	wire tableClear = lineEnd && lineWord_reg[LT_CLEAR];
	wire lineInc = lineEnd && !lineHoldZero && !lineStuck;

	// ----------------------------------------------------------------
	// Line clear source
	// ----------------------------------------------------------------
	logic lineClear;

	always_comb
	begin
		case (cfg.lineClearSourceSel)
			CTS_CLEAR_OFF: lineClear = 1'b0;
			CTS_CLEAR_TABLE: lineClear = tableClear;
			CTS_CLEAR_TRIGGER: lineClear = triggerRise;
			CTS_CLEAR_EITHER: lineClear = tableClear || triggerRise;
			default: lineClear = 1'b0;
		endcase
	end

	always_comb
	begin
		// Load wins here, unlike the row counter
		lineCount_next = lineCount_reg;
		if (lineLoad)
			lineCount_next = LINE_LOAD_ADDR;
		else if (lineClear)
			lineCount_next = LINE_ZERO_ADDR;
		else if (lineInc)
			lineCount_next = lineCount_reg + 17'h00001;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			lineCount_reg <= LINE_ZERO_ADDR;
		else
			lineCount_reg <= lineCount_next;
	end

	// ----------------------------------------------------------------
	// Acquisition window starts
	// ----------------------------------------------------------------
	wire frameBeginNow = cfg.frameStartFromTable ? (lineEnd && lineWord_reg[LT_WINDOW_BEGIN]) : frameEdge;
	wire rowBeginNow = cfg.rowStartFromTable ? (groupTick && rowWord_reg[PT_WINDOW_BEGIN]) : lineStart;

	logic vertBegin_reg;
	logic rowBegin_reg;
	logic rowActive_reg;
	logic [WINDOW_LEN_W-1:0] windowLeft_reg;
	logic [WINDOW_LEN_W-1:0] windowLeft_next;

	// ----------------------------------------------------------------
	// Row window length
	// ----------------------------------------------------------------
	// Window length counts pixel clocks, not groups
	always_comb
	begin
		windowLeft_next = windowLeft_reg;
		if (rowBeginNow)
			windowLeft_next = cfg.activeClocksPerRow;
		else if (pixelEdge && windowLeft_reg != WINDOW_RESET)
			windowLeft_next = windowLeft_reg - 17'h00001;
	end

	// Frame begin is a one-cycle pulse, never a level
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			vertBegin_reg <= 1'b0;
		else
			vertBegin_reg <= frameBeginNow;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			rowBegin_reg <= 1'b0;
			rowActive_reg <= 1'b0;
			windowLeft_reg <= WINDOW_RESET;
		end
		else
		begin
			rowBegin_reg <= rowBeginNow;
			windowLeft_reg <= windowLeft_next;
			rowActive_reg <= (windowLeft_next != WINDOW_RESET);
		end
	end

	// ----------------------------------------------------------------
	// Camera control combination
	// ----------------------------------------------------------------
	// Both words are registered, so controls lag the words one cycle
	logic [3:0] camCtl_reg;

	for (genvar i = 0; i < 4; i++)
	begin : g_cam_ctl
		always_ff @(posedge ref_clk or posedge reset)
		begin
			if (reset)
				camCtl_reg[i] <= 1'b0;
			else
				camCtl_reg[i] <= lineWord_reg[LT_GENERAL_LSB+i] & rowWord_reg[PT_GENERAL_LSB+i];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign linePositionCount = lineCount_reg;
	assign pixelGroupCount = rowCount_reg;
	assign lineWord = lineWord_reg;
	assign rowWord = rowWord_reg;
	assign vertWindowBegin = vertBegin_reg;
	assign rowWindowBegin = rowBegin_reg;
	assign rowActiveWindow = rowActive_reg;
	// Interrupt is a level; any latching is left to the host side
	assign hostIrqRequest = lineWord_reg[LT_HOST_IRQ];
	assign generalVertFn = lineWord_reg[LT_GENERAL_LSB+:4];
	assign generalRowFn = rowWord_reg[PT_GENERAL_LSB+:4];
	assign cameraControl = camCtl_reg;

endmodule

//--- tb/cts_asserts.sv
// Port checks for the control table sequencer
module cts_asserts
	import cts_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic triggerIn,
	input wire cts_cfg_t cfg,
	input wire logic [LINE_ADDR_W-1:0] linePositionCount,
	input wire logic [ROW_ADDR_W-1:0] pixelGroupCount,
	input wire logic [TABLE_DATA_W-1:0] lineWord,
	input wire logic [TABLE_DATA_W-1:0] rowWord,
	input wire logic vertWindowBegin,
	input wire logic rowWindowBegin,
	input wire logic rowActiveWindow,
	input wire logic hostIrqRequest,
	input wire logic [3:0] cameraControl
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [16:0] lpc = linePositionCount;
	wire logic [14:0] pgc = pixelGroupCount;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// ------------------------------
	// Relations
	// ------------------------------
	// Implications keep unwritten table words from firing checks
	irq_level_a: assert property (lineWord[LT_HOST_IRQ] |-> hostIrqRequest)
		else $error("irq not set by line word");
	cam_and_a: assert property (lineWord[4] && rowWord[4] |=> cameraControl[0])
		else $error("control output not set");
	line_step_a: assert property ($changed(lpc) && lpc != 0 && lpc != LINE_LOAD_ADDR
		|-> lpc == $past(lpc) + 17'h1 && $past(rowWord[PT_CLEAR]))
		else $error("line count moved without line end");
	line_load_a: assert property ($changed(lpc) && lpc == LINE_LOAD_ADDR && $past(lpc) != 17'h07fff
		|-> $past(lineWord[LT_FRAME_LOAD_MASK]) || $past(lpc) == LINE_STICK_ADDR)
		else $error("line load without mask");
	line_stick_a: assert property (lpc == LINE_STICK_ADDR && cfg.lineStickReleaseSel
		|=> lpc == LINE_STICK_ADDR || lpc == LINE_LOAD_ADDR || lpc == 0)
		else $error("line count left stick");
	zero_hold_a: assert property (lpc == 0 && cfg.lineZeroReleaseSel && !triggerIn && !$past(triggerIn)
		&& !$past(triggerIn, 2) && !$past(triggerIn, 3) |=> lpc != 17'h1)
		else $error("line count left zero");
	row_step_a: assert property ($changed(pgc) && pgc != 0 && pgc != ROW_LOAD_ADDR
		|-> pgc == $past(pgc) + 15'h1)
		else $error("group count skipped");
	row_load_a: assert property ($changed(pgc) && pgc == ROW_LOAD_ADDR && $past(pgc) != 15'h1fff
		|-> $past(rowWord[PT_LINE_LOAD_MASK]) || $past(pgc) == ROW_STICK_ADDR)
		else $error("group load without mask");
	row_stick_a: assert property (pgc == ROW_STICK_ADDR && cfg.rowStickReleaseSel
		|=> pgc == ROW_STICK_ADDR || pgc == ROW_LOAD_ADDR || pgc == 0)
		else $error("group count left stick");
	begin_pulse_a: assert property (vertWindowBegin |=> !vertWindowBegin)
		else $error("frame window begin too long");
	row_window_a: assert property (rowWindowBegin && cfg.activeClocksPerRow != 0 |-> rowActiveWindow)
		else $error("row window not open");
	cover property (lpc == LINE_LOAD_ADDR);
	cover property (pgc == ROW_LOAD_ADDR);
	cover property (hostIrqRequest);
endmodule

bind cts_control_table_sequencer cts_asserts i_chk (.ref_clk(ref_clk), .reset(reset), .triggerIn(triggerIn),
	.cfg(cfg), .linePositionCount(linePositionCount), .pixelGroupCount(pixelGroupCount), .lineWord(lineWord),
	.rowWord(rowWord), .vertWindowBegin(vertWindowBegin), .rowWindowBegin(rowWindowBegin),
	.rowActiveWindow(rowActiveWindow), .hostIrqRequest(hostIrqRequest), .cameraControl(cameraControl));

//--- tb/cts_camera_model.sv
// Camera model: pixel clock, line and frame valid levels
module cts_camera_model
(
	input wire logic run,
	input wire logic lineReq,
	input wire logic frameReq,
	output logic pixelClock,
	output logic lineValid,
	output logic frameValid
);
	timeunit 1ns;
	timeprecision 1ns;
	// Offset keeps pixel edges away from reference clock edges
	initial
	begin
		pixelClock = 1'b0;
		#7;
		forever
		begin
			#100;
			if (run)
				pixelClock = ~pixelClock;
		end
	end
	always @(negedge pixelClock)
	begin
		lineValid <= lineReq;
		frameValid <= frameReq;
	end
	initial
	begin
		lineValid = 1'b0;
		frameValid = 1'b0;
	end
endmodule

//--- tb/tb_control_table_sequencer.sv
// Self-checking bench for the control table sequencer
module tb_control_table_sequencer
	import cts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, reset, triggerIn, encoderIn, run, lineReq, frameReq, pixelClockIn, lineValidIn, frameValidIn;
	logic vertWindowBegin, rowWindowBegin, rowActiveWindow, hostIrqRequest;
	logic [LINE_ADDR_W-1:0] linePositionCount;
	logic [ROW_ADDR_W-1:0] pixelGroupCount;
	logic [7:0] lineWord, rowWord;
	logic [3:0] generalVertFn, generalRowFn, cameraControl;
	cts_cfg_t cfg;
	cts_table_wr_t tableWr;
	int errorCnt = 0, samplesChecked = 0, cycles = 0, n;
	// Line word, then irq at bit 4 and general bits below
	logic [15:0] rows [4] = '{16'h0810, 16'h5005, 16'ha81a, 16'hf70f};
	cts_control_table_sequencer i_dut (.ref_clk(ref_clk), .reset(reset), .pixelClockIn(pixelClockIn),
		.lineValidIn(lineValidIn), .frameValidIn(frameValidIn), .triggerIn(triggerIn), .encoderIn(encoderIn),
		.cfg(cfg), .tableWr(tableWr), .linePositionCount(linePositionCount), .pixelGroupCount(pixelGroupCount),
		.lineWord(lineWord), .rowWord(rowWord), .vertWindowBegin(vertWindowBegin), .rowWindowBegin(rowWindowBegin),
		.rowActiveWindow(rowActiveWindow), .hostIrqRequest(hostIrqRequest), .generalVertFn(generalVertFn),
		.generalRowFn(generalRowFn), .cameraControl(cameraControl));
	cts_camera_model i_cam (.run(run), .lineReq(lineReq), .frameReq(frameReq), .pixelClock(pixelClockIn),
		.lineValid(lineValidIn), .frameValid(frameValidIn));
	initial
	begin
		ref_clk = 1'b0;
		forever
			#20 ref_clk = ~ref_clk;
	end
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic stopTest();
		$display("checks %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			errorCnt++;
			stopTest();
		end
	end
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		samplesChecked++;
		if (exp !== got)
		begin
			errorCnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic lineSel, input logic [16:0] addr, input logic [7:0] data);
		@(negedge ref_clk);
		tableWr = '{lineWrite: lineSel, rowWrite: !lineSel, addr: addr, data: data};
		@(negedge ref_clk);
		tableWr = '0;
	endtask
	function automatic logic [16:0] cnt(input logic rowSel);
		return rowSel ? {2'b00, pixelGroupCount} : linePositionCount;
	endfunction
	task automatic waitFor(input logic rowSel, input logic [16:0] val, input int lim);
		n = 0;
		while (n < lim && cnt(rowSel) !== val)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic waitMove(input logic rowSel, input int lim);
		logic [16:0] start;
		start = cnt(rowSel);
		n = 0;
		while (n < lim && cnt(rowSel) === start)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	// ------------------------------
	// Sequence
	// ------------------------------
	initial
	begin
		reset = 1'b1;
		{triggerIn, encoderIn, run, lineReq, frameReq} = 5'h00;
		tableWr = '0;
		cfg = '{lineClearSourceSel: CTS_CLEAR_TABLE, lineZeroReleaseSel: 1'b1, default: '0};
		cfg.activeClocksPerRow = 17'h00010;
		repeat (8) @(negedge ref_clk);
		chk("lineCount", 17'h0, cnt(1'b0));
		chk("groupCount", 17'h0, cnt(1'b1));
		reset = 1'b0;
		$display("reset test done");
		for (int i = 0; i < 8; i++)
			wr(1'b1, 17'(i), i == 2 ? 8'h02 : i == 4 ? 8'h04 : 8'h00);
		for (int i = 0; i < 4; i++)
			wr(1'b0, 17'(i), i == 0 ? 8'h10 : i == 3 ? 8'h02 : 8'h00);
		wr(1'b0, 17'h02000, 8'h02);
		wr(1'b1, 17'h08000, 8'h02);
		foreach (rows[i])
		begin
			wr(1'b1, 17'h0, rows[i][15:8]);
			repeat (4) @(negedge ref_clk);
			chk("lineWord", {9'h0, rows[i][15:8]}, {9'h0, lineWord});
			chk("irq", {16'h0, rows[i][4]}, {16'h0, hostIrqRequest});
			chk("generalVert", {13'h0, rows[i][3:0]}, {13'h0, generalVertFn});
			chk("cameraControl", {13'h0, rows[i][15:12] & 4'h1}, {13'h0, cameraControl});
			chk("generalRow", 17'h1, {13'h0, generalRowFn});
			chk("lineCount", 17'h0, cnt(1'b0));
		end
		wr(1'b1, 17'h0, 8'h00);
		$display("table word test done");
		run = 1'b1;
		waitFor(1'b1, 17'h1, 200);
		waitMove(1'b1, 100);
		chk("groupPeriod", 17'd40, 17'(n));
		chk("groupCount", 17'h2, cnt(1'b1));
		waitFor(1'b1, 17'h3, 100);
		waitMove(1'b1, 100);
		chk("groupCount", 17'h0, cnt(1'b1));
		chk("lineCount", 17'h0, cnt(1'b0));
		$display("group scan test done");
		triggerIn = 1'b1;
		waitFor(1'b0, 17'h1, 400);
		chk("lineCount", 17'h1, cnt(1'b0));
		chk("groupCount", 17'h0, cnt(1'b1));
		triggerIn = 1'b0;
		waitFor(1'b0, 17'h2, 400);
		waitMove(1'b0, 400);
		chk("lineCount", 17'h0, cnt(1'b0));
		repeat (200) @(negedge ref_clk);
		chk("lineCount", 17'h0, cnt(1'b0));
		cfg.lineClearSourceSel = CTS_CLEAR_OFF;
		triggerIn = 1'b1;
		waitFor(1'b0, 17'h3, 700);
		chk("lineCount", 17'h3, cnt(1'b0));
		triggerIn = 1'b0;
		frameReq = 1'b1;
		repeat (30) @(negedge ref_clk);
		chk("lineCount", 17'h3, cnt(1'b0));
		frameReq = 1'b0;
		waitFor(1'b0, 17'h4, 200);
		cfg.lineClearSourceSel = CTS_CLEAR_TABLE;
		frameReq = 1'b1;
		waitFor(1'b0, 17'h08000, 60);
		chk("lineCount", 17'h08000, cnt(1'b0));
		chk("vertBegin", 17'h1, {16'h0, vertWindowBegin});
		waitFor(1'b0, 17'h0, 200);
		wr(1'b1, 17'h0, 8'h04);
		cfg.frameEdgePolarity = 1'b1;
		frameReq = 1'b0;
		waitFor(1'b0, 17'h08000, 60);
		chk("lineCount", 17'h08000, cnt(1'b0));
		waitFor(1'b0, 17'h0, 200);
		frameReq = 1'b1;
		repeat (30) @(negedge ref_clk);
		chk("lineCount", 17'h0, cnt(1'b0));
		$display("frame load test done");
		wr(1'b0, 17'h1, 8'h04);
		waitFor(1'b1, 17'h1, 200);
		lineReq = 1'b1;
		waitFor(1'b1, 17'h02000, 40);
		chk("groupCount", 17'h02000, cnt(1'b1));
		chk("rowBegin", 17'h1, {16'h0, rowWindowBegin});
		chk("rowActive", 17'h1, {16'h0, rowActiveWindow});
		waitMove(1'b1, 60);
		chk("groupCount", 17'h0, cnt(1'b1));
		chk("rowActive", 17'h1, {16'h0, rowActiveWindow});
		lineReq = 1'b0;
		repeat (80) @(negedge ref_clk);
		chk("rowActive", 17'h0, {16'h0, rowActiveWindow});
		$display("row load test done");
		stopTest();
	end
endmodule
